/* core/rmda_consts.vh */
`ifndef RMDA_CONSTS_VH
`define RMDA_CONSTS_VH
// register offsets (4-bit word address on the plain port)
`define RMDA_ADDR_W 4
`define RMDA_REG_CTRL 4'h0
`define RMDA_REG_FIXED 4'h1
`define RMDA_REG_TRIG 4'h2
`define RMDA_REG_STATUS 4'h3
`define RMDA_REG_APPLIED 4'h4
`define RMDA_REG_ESTIM 4'h5
// ctrl fields
`define RMDA_CTRL_MODE_LSB 0
`define RMDA_CTRL_PATH_BIT 2
// modes
`define RMDA_MODE_START 2'h0
`define RMDA_MODE_AUTO 2'h1
`define RMDA_MODE_MANUAL 2'h2
// trigger bits
`define RMDA_TRIG_EST_BIT 0
`define RMDA_TRIG_FIX_BIT 1
// delay limits and reset values
`define RMDA_MAX_DELAY 12'h960
`define RMDA_DLY_W 12
`define RMDA_FIXED_RST 12'h000
`define RMDA_SAMPLE_W 16
`endif

/* core/rmda_delay_line.v */
`timescale 1ns/1ps
`default_nettype none
`include "rmda_consts.vh"
module rmda_delay_line #(
  parameter DEPTH = 4096,
  parameter AW = 12,
  parameter DW = 16
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire strobe_i,
  input wire [AW-1:0] delay_i,
  input wire [DW-1:0] data_i,
  output reg [DW-1:0] data_o
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  wire [AW-1:0] rd_addr;

  // read tap sits delay_i samples behind the write pointer
  assign rd_addr = wr_ff - delay_i;

  // write memory on each sample
  always @(posedge clock_i) begin
    if (ce_i && strobe_i) begin
      mem[wr_ff] <= data_i;
    end
  end

  // pointer and output; zero delay passes the new sample through
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ff <= {AW{1'b0}};
      data_o <= {DW{1'b0}};
    end else if (ce_i && strobe_i) begin
      wr_ff <= wr_ff + 1'b1;
      data_o <= (delay_i == {AW{1'b0}}) ? data_i : mem[rd_addr];
    end
  end
endmodule // rmda_delay_line
`default_nettype wire

/* core/rmda_aligner.v */
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rmda_consts.vh"
module rmda_aligner (
  input wire clock_i,
  input wire resetn_i,
  input wire ce_i,
  input wire [`RMDA_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire sample_i,
  input wire [`RMDA_SAMPLE_W-1:0] ref_i,
  input wire [`RMDA_SAMPLE_W-1:0] mic_i,
  input wire est_valid_i,
  input wire [`RMDA_DLY_W-1:0] est_delay_i,
  output wire est_enable_o,
  output wire [`RMDA_SAMPLE_W-1:0] ref_o,
  output wire [`RMDA_SAMPLE_W-1:0] mic_o,
  output reg sample_o
);
  ////////////////////////////////////////////////////////////////////////
  // states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EST = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;

  reg rst_a_ff;
  reg rst_b_ff;
  wire rst_n;
  reg [1:0] mode_ff;
  reg path_ff;
  reg [`RMDA_DLY_W-1:0] fixed_ff;
  reg [`RMDA_DLY_W-1:0] pend_ff;
  reg [`RMDA_DLY_W-1:0] applied_ff;
  reg [`RMDA_DLY_W-1:0] estim_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [`RMDA_DLY_W-1:0] nxt_pend;
  reg trig_est;
  reg trig_fix;
  reg mode_wr;
  reg [`RMDA_DLY_W-1:0] ref_dly;
  reg [`RMDA_DLY_W-1:0] mic_dly;

  // clamp a delay to the documented maximum
  function [`RMDA_DLY_W-1:0] clamp_dly;
    input [`RMDA_DLY_W-1:0] d;
    begin
      if (d > `RMDA_MAX_DELAY) begin
        clamp_dly = `RMDA_MAX_DELAY;
      end else begin
        clamp_dly = d;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  assign rst_n = rst_b_ff;

  ////////////////////////////////////////////////////////////////////////
  // write decode
  always @* begin
    trig_est = 1'b0;
    trig_fix = 1'b0;
    mode_wr = 1'b0;
    if (wr_i && addr_i == `RMDA_REG_TRIG) begin
      trig_est = wdata_i[`RMDA_TRIG_EST_BIT];
      trig_fix = wdata_i[`RMDA_TRIG_FIX_BIT];
    end
    if (wr_i && addr_i == `RMDA_REG_CTRL) begin
      mode_wr = 1'b1;
    end
  end

  // config registers; mode resets to start-up estimate
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= `RMDA_MODE_START;
      path_ff <= 1'b0;
      fixed_ff <= `RMDA_FIXED_RST;
    end else if (ce_i && wr_i) begin
      if (mode_wr) begin
        // reserved code 3 is ignored, keeping three modes
        if (wdata_i[1:0] != 2'h3) begin
          mode_ff <= wdata_i[1:0];
        end
        path_ff <= wdata_i[`RMDA_CTRL_PATH_BIT];
      end
      if (addr_i == `RMDA_REG_FIXED) begin
        fixed_ff <= clamp_dly(wdata_i[`RMDA_DLY_W-1:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode controller
  always @* begin
    nxt_state = state_ff;
    nxt_pend = pend_ff;
    case (state_ff)
      ST_IDLE: begin
        if (mode_ff != `RMDA_MODE_MANUAL) begin
          nxt_state = ST_EST;
        end
      end
      ST_EST: begin
        if (est_valid_i) begin
          nxt_pend = clamp_dly(est_delay_i);
          if (mode_ff != `RMDA_MODE_AUTO) begin
            nxt_state = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (mode_ff == `RMDA_MODE_AUTO) begin
          nxt_state = ST_EST;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // leaving for manual stops a running estimate and keeps the delay
    if (mode_wr && wdata_i[1:0] == `RMDA_MODE_MANUAL) begin
      nxt_state = ST_IDLE;
      nxt_pend = pend_ff;
    end
    // host trigger overrides any state
    if (trig_fix) begin
      nxt_pend = fixed_ff;
      nxt_state = ST_HOLD;
    end else if (trig_est) begin
      nxt_state = ST_EST;
    end
  end

  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      pend_ff <= {`RMDA_DLY_W{1'b0}};
      estim_ff <= {`RMDA_DLY_W{1'b0}};
    end else if (ce_i) begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      if (est_valid_i) begin
        estim_ff <= clamp_dly(est_delay_i);
      end
    end
  end

  // estimator runs only while estimating
  assign est_enable_o = state_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // applied delay changes only with a sample strobe
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      applied_ff <= {`RMDA_DLY_W{1'b0}};
      sample_o <= 1'b0;
    end else if (ce_i) begin
      sample_o <= sample_i;
      if (sample_i) begin
        applied_ff <= pend_ff;
      end
    end
  end

  // the delay is steered to exactly one stream
  always @* begin
    ref_dly = path_ff ? {`RMDA_DLY_W{1'b0}} : applied_ff;
    mic_dly = path_ff ? applied_ff : {`RMDA_DLY_W{1'b0}};
  end

  rmda_delay_line #(
    .DEPTH(4096),
    .AW(`RMDA_DLY_W),
    .DW(`RMDA_SAMPLE_W)
  ) u_ref (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .strobe_i(sample_i),
    .delay_i(ref_dly),
    .data_i(ref_i),
    .data_o(ref_o)
  );

  rmda_delay_line #(
    .DEPTH(4096),
    .AW(`RMDA_DLY_W),
    .DW(`RMDA_SAMPLE_W)
  ) u_mic (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .strobe_i(sample_i),
    .delay_i(mic_dly),
    .data_i(mic_i),
    .data_o(mic_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe, zero otherwise
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      rdata_o <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          `RMDA_REG_CTRL: rdata_o <= {29'h0, path_ff, mode_ff};
          `RMDA_REG_FIXED: rdata_o <= {20'h0, fixed_ff};
          `RMDA_REG_STATUS: rdata_o <= {29'h0, state_ff};
          `RMDA_REG_APPLIED: rdata_o <= {20'h0, applied_ff};
          `RMDA_REG_ESTIM: rdata_o <= {20'h0, estim_ff};
          default: rdata_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // rmda_aligner
`default_nettype wire

/* tb/rmda_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rmda_consts.vh"
module rmda_props (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic sample_i,
  input wire logic [15:0] ref_i,
  input wire logic [15:0] mic_i,
  input wire logic est_enable_o,
  input wire logic [15:0] ref_o,
  input wire logic [15:0] mic_o,
  input wire logic sample_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // mode writes on the register port
  wire logic cw = wr_i && addr_i == `RMDA_REG_CTRL;
  wire logic [1:0] md = wdata_i[1:0];
  ////////////////////
  // stream timing, path choice and estimator enable
  AST_SAMPLE_OUT: assert property (sample_i |=> sample_o)
    else $error("sample lost");
  AST_NO_EXTRA: assert property (sample_o |-> $past(sample_i))
    else $error("extra sample");
  AST_HOLD_OUT: assert property (!$past(sample_i) |-> $stable(ref_o)
    && $stable(mic_o)) else $error("output moved");
  AST_ONE_PATH: assert property (sample_o |-> ref_o == $past(ref_i)
    || mic_o == $past(mic_i)) else $error("both paths delayed");
  AST_START_EST: assert property ($rose(resetn_i) |-> ##[1:6]
    est_enable_o) else $error("no start-up estimate");
  AST_AUTO_EST: assert property (cw && md == `RMDA_MODE_AUTO |->
    ##[1:3] est_enable_o) else $error("auto not estimating");
  AST_MANUAL_IDLE: assert property (cw && md == `RMDA_MODE_MANUAL |->
    ##[1:3] !est_enable_o) else $error("manual not idle");
  // main scenarios reached
  cover property (cw && md == `RMDA_MODE_AUTO);
  cover property ($fell(est_enable_o));
  cover property (sample_o && ref_o != $past(ref_i));
endmodule // rmda_props
bind rmda_aligner rmda_props i_props (.clock_i(clock_i),
  .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .sample_i(sample_i), .ref_i(ref_i), .mic_i(mic_i), .ref_o(ref_o),
  .est_enable_o(est_enable_o), .mic_o(mic_o), .sample_o(sample_o));
`default_nettype wire

/* tb/rmda_est_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rmda_est_model (
  input wire logic clock_i,
  input wire logic en_i,
  input wire logic [11:0] dly_i,
  output logic valid_o = 1'h0,
  output logic [11:0] delay_o = 12'h000
);
  logic [2:0] cnt = 3'h0;
  // one estimate every eighth cycle while enabled, junk otherwise
  always @(posedge clock_i) begin
    cnt <= en_i ? cnt + 3'h1 : 3'h0;
    valid_o <= en_i && cnt == 3'h7;
    delay_o <= (en_i && cnt == 3'h7) ? dly_i : ~dly_i;
  end
endmodule // rmda_est_model
`default_nettype wire

/* tb/rmda_aligner_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rmda_consts.vh"
`define C(g,e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
$display("BAD %0t %h %h", $time, g, e); end end
module rmda_aligner_tb;
  logic clock_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, sample_i = 0;
  logic ce_i = 1;
  logic [3:0] addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o;
  logic [15:0] ref_i = 0, mic_i = 0, ref_o, mic_o, k = 0;
  logic est_valid_i, est_enable_o, sample_o;
  logic [11:0] est_delay_i, mdl = 12'h005;
  int mismatches = 0, n_tests = 0;
  // rows: address, write data, expected read back
  logic [67:0] rows [4] = '{{4'h1, 32'h10, 32'h10},
    {4'h1, 32'hFFF, 32'h960}, {4'h0, 32'h7, 32'h5}, {4'hF, 32'h1, 32'h0}};
  rmda_aligner i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sample_i(sample_i), .ref_i(ref_i), .mic_i(mic_i),
    .est_valid_i(est_valid_i), .est_delay_i(est_delay_i), .ref_o(ref_o),
    .est_enable_o(est_enable_o), .mic_o(mic_o), .sample_o(sample_o));
  rmda_est_model i_est (.clock_i(clock_i), .en_i(est_enable_o),
    .dly_i(mdl), .valid_o(est_valid_i), .delay_o(est_delay_i));
  initial forever #50 clock_i = ~clock_i;
  // bus cycles, samples and pauses
  task w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clock_i);
    wr_i <= 0;
  endtask
  task r(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clock_i);
    rd_i <= 0;
    #1 `C(rdata_o, e)
  endtask
  task s(input int d, input logic mp, input logic c);
    @(posedge clock_i);
    sample_i <= 1;
    ref_i <= k;
    mic_i <= k + 16'h8000;
    @(posedge clock_i);
    sample_i <= 0;
    #1 if (c) begin
      `C(sample_o, 1'h1)
      `C(ref_o, mp ? k : 16'(k - d))
      `C(mic_o, 16'(k + 16'h8000 - (mp ? d : 0)))
    end
    k++;
  endtask
  task p;
    repeat (40) @(posedge clock_i);
  endtask
  task t;
    $display("test end %0t", $time);
  endtask
  task stop_test;
    $display("checks %0d bad %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  initial begin
    #1000000;
    mismatches++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1;
    p;
    r(`RMDA_REG_CTRL, 0);
    mdl <= 7;
    for (int i = 0; i < 8; i++) s(5, 0, i >= 5);
    p;
    r(`RMDA_REG_APPLIED, 5);
    t;
    w(`RMDA_REG_CTRL, 2);
    w(`RMDA_REG_FIXED, 32'h960);
    w(`RMDA_REG_TRIG, 2);
    for (int i = 0; i < 2400; i++) s(2400, 0, i >= 2392);
    r(`RMDA_REG_APPLIED, 32'h960);
    w(`RMDA_REG_FIXED, 3);
    s(2400, 0, 1);
    r(`RMDA_REG_APPLIED, 32'h960);
    w(`RMDA_REG_CTRL, 6);
    w(`RMDA_REG_TRIG, 2);
    for (int i = 0; i < 11; i++) s(3, 1, i >= 3);
    mdl <= 9;
    w(`RMDA_REG_TRIG, 1);
    p;
    s(3, 1, 1);
    r(`RMDA_REG_APPLIED, 9);
    mdl <= 4;
    p;
    s(9, 1, 1);
    r(`RMDA_REG_APPLIED, 9);
    t;
    w(`RMDA_REG_CTRL, 1);
    p;
    s(9, 0, 1);
    r(`RMDA_REG_APPLIED, 4);
    mdl <= 11;
    p;
    s(4, 0, 1);
    r(`RMDA_REG_APPLIED, 11);
    r(`RMDA_REG_ESTIM, 11);
    foreach (rows[i]) begin
      w(rows[i][67:64], rows[i][63:32]);
      r(rows[i][67:64], rows[i][31:0]);
    end
    t;
    // frozen by clock enable: the write must not land
    ce_i <= 0;
    w(`RMDA_REG_FIXED, 7);
    ce_i <= 1;
    r(`RMDA_REG_FIXED, 32'h960);
    `C(est_enable_o, 1'h1)
    // auto to manual stops the estimator at once
    w(`RMDA_REG_CTRL, 2);
    r(`RMDA_REG_STATUS, 1);
    `C(est_enable_o, 1'h0)
    // both trigger bits: the fixed delay wins
    w(`RMDA_REG_TRIG, 3);
    s(11, 0, 1);
    r(`RMDA_REG_APPLIED, 32'h960);
    r(`RMDA_REG_STATUS, 4);
    t;
    resetn_i <= 0;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1;
    p;
    r(`RMDA_REG_CTRL, 0);
    s(0, 0, 1);
    r(`RMDA_REG_APPLIED, 11);
    t;
    stop_test;
  end
endmodule // rmda_aligner_tb
`default_nettype wire
